// ---- fhs_cal_engine_model.sv ----
// calibration engine stand-in feeding results to the register bank
`timescale 1ns/10ps
`default_nettype none
module fhs_cal_engine_model
	import fhs_pkg::*;
(
	input wire logic hclk, // clock
	input wire logic go, // start one run
	input wire logic [3:0] dly, // cycles before the result
	input var fhs_cal_t val, // result to report
	output var logic cal_done, // one-cycle strobe
	output var fhs_cal_t cal_result // result, scrambled when idle
);
	initial {cal_done, cal_result} = '0;
	// result stands only with the strobe, so a late capture shows up
	always @(posedge hclk) begin
		if (go) begin
			repeat (dly) @(posedge hclk);
			cal_done <= 1'b1;
			cal_result <= val;
			@(posedge hclk);
			cal_done <= 1'b0;
			cal_result <= ~val;
		end
	end
endmodule
`default_nettype wire

// ---- fhs_cal_mux.sv ----
// selects the active frequency set and forced or own calibration values
`timescale 1ns/10ps
`default_nettype none
module fhs_cal_mux
	import fhs_pkg::*;
(
	input wire logic fsel,            // 0 set a, 1 set b
	input var fhs_freq_t freq_set_a,  // frequency set a
	input var fhs_freq_t freq_set_b,  // frequency set b
	input var fhs_force_t force_en,   // per-field force enables
	input var fhs_cal_t forced,       // values written by software
	input var fhs_cal_t own,          // values from own calibration
	output var fhs_freq_t freq_sel,   // frequency for the synthesizer
	output var fhs_cal_t cal_sel      // calibration in use
);
	// the select bit alone decides the set, so either set can be
	// rewritten while the other one drives the synthesizer
	always_comb begin
		freq_sel = fsel ? freq_set_b : freq_set_a;
	end

	// each field is forced on its own enable
	always_comb begin
		cal_sel.pump = force_en.pump ? forced.pump : own.pump;
		cal_sel.osc_array = force_en.osc_array ? forced.osc_array : own.osc_array;
		cal_sel.osc_current = force_en.osc_current ? forced.osc_current
			: own.osc_current;
	end
endmodule
`default_nettype wire

// ---- fhs_consts.svh ----
// constants for the hop channel switch and calibration override register bank
// Contract
// - two frequency sets, inactive one writable
// - main bit 6 picks set a or b
// - stored results go into override fields
// - force enables replace own calibration values
// - every configuration register is eight bits
// - programmed reset restores all register defaults; a result strobe in the same cycle loads the results instead
`ifndef FHS_CONSTS_SVH
`define FHS_CONSTS_SVH

// register indices, byte address is four times the index
`define FHS_IDX_MAIN 8'h00
`define FHS_IDX_SOFT_RESET 8'h02
`define FHS_IDX_FREQ2A 8'h04
`define FHS_IDX_FREQ1A 8'h05
`define FHS_IDX_FREQ0A 8'h06
`define FHS_IDX_FREQ2B 8'h08
`define FHS_IDX_FREQ1B 8'h09
`define FHS_IDX_FREQ0B 8'h0A
`define FHS_IDX_OVR_PUMP 8'h21
`define FHS_IDX_OVR_OSC_ARRAY 8'h22
`define FHS_IDX_OVR_OSC_CURRENT 8'h23
`define FHS_IDX_RES_PUMP 8'h45
`define FHS_IDX_RES_OSC_ARRAY 8'h46
`define FHS_IDX_RES_OSC_CURRENT 8'h47

// storage slots of the writable registers
`define FHS_SLOT_MAIN 4'h0
`define FHS_SLOT_FREQ2A 4'h1
`define FHS_SLOT_FREQ1A 4'h2
`define FHS_SLOT_FREQ0A 4'h3
`define FHS_SLOT_FREQ2B 4'h4
`define FHS_SLOT_FREQ1B 4'h5
`define FHS_SLOT_FREQ0B 4'h6
`define FHS_SLOT_OVR_PUMP 4'h7
`define FHS_SLOT_OVR_OSC_ARRAY 4'h8
`define FHS_SLOT_OVR_OSC_CURRENT 4'h9
`define FHS_SLOT_NONE 4'hF
`define FHS_NUM_SLOTS 10

// reset values
`define FHS_MAIN_RST 8'h88
`define FHS_CFG_RST 8'h00
`define FHS_ZERO8 8'h00

// field positions
`define FHS_MAIN_FSEL_BIT 6
`define FHS_SOFT_RESET_BIT 0
`define FHS_OSC_ARRAY_FORCE_BIT 5
`define FHS_PUMP_FORCE_BIT 6
`define FHS_OSC_CURRENT_FORCE_BIT 6

// bus encodings
`define FHS_HTRANS_NONSEQ_BIT 1
`define FHS_HRESP_OKAY 1'h0

`endif

// ---- fhs_hop_regs.sv ----
// register bank for fast channel hopping with calibration overrides
`timescale 1ns/10ps
`default_nettype none
`include "fhs_consts.svh"
module fhs_hop_regs
	import fhs_pkg::*;
(
	input wire logic hclk,              // bus clock, 200 MHz
	input wire logic hresetn,           // async reset, active low
	input wire logic hsel,              // slave select
	input wire logic [31:0] haddr,      // byte address
	input wire logic [1:0] htrans,      // transfer type
	input wire logic hwrite,            // write when high
	input wire logic [2:0] hsize,       // word only
	input wire logic [31:0] hwdata,     // write data
	input wire logic hready,            // bus ready in
	output logic [31:0] hrdata,         // read data
	output logic hreadyout,             // always ready
	output logic hresp,                 // always okay
	input wire logic cal_done,          // pulse: calibration finished
	input var fhs_cal_t cal_result,     // results valid with cal_done
	output fhs_freq_t synth_freq,       // active frequency word
	output fhs_cal_t synth_cal,         // calibration in use
	output logic freq_set_sel           // active set, 0 a, 1 b
);
	logic [7:0] cfg_r [`FHS_NUM_SLOTS]; // writable registers
	fhs_cal_t res_r;                    // own calibration results
	logic dp_wr_r;                      // write data phase pending
	logic [7:0] dp_idx_r;               // index of that write
	logic [7:0] aidx;                   // index in address phase
	logic atake;                        // address phase accepted
	logic soft_rst;                     // programmed reset this cycle
	logic [3:0] dp_slot;                // slot of the pending write
	logic [31:0] rd_word;               // read data for next phase
	fhs_freq_t fa;                      // set a view
	fhs_freq_t fb;                      // set b view
	fhs_force_t fen;                    // force enables
	fhs_cal_t fval;                     // forced values
	fhs_freq_t freq_nxt;                // selected frequency
	fhs_cal_t cal_nxt;                  // selected calibration

	// index to storage slot, used by write and read paths
	function automatic logic [3:0] slot_of(input logic [7:0] idx);
		case (idx)
			`FHS_IDX_MAIN: slot_of = `FHS_SLOT_MAIN;
			`FHS_IDX_FREQ2A: slot_of = `FHS_SLOT_FREQ2A;
			`FHS_IDX_FREQ1A: slot_of = `FHS_SLOT_FREQ1A;
			`FHS_IDX_FREQ0A: slot_of = `FHS_SLOT_FREQ0A;
			`FHS_IDX_FREQ2B: slot_of = `FHS_SLOT_FREQ2B;
			`FHS_IDX_FREQ1B: slot_of = `FHS_SLOT_FREQ1B;
			`FHS_IDX_FREQ0B: slot_of = `FHS_SLOT_FREQ0B;
			`FHS_IDX_OVR_PUMP: slot_of = `FHS_SLOT_OVR_PUMP;
			`FHS_IDX_OVR_OSC_ARRAY: slot_of = `FHS_SLOT_OVR_OSC_ARRAY;
			`FHS_IDX_OVR_OSC_CURRENT: slot_of = `FHS_SLOT_OVR_OSC_CURRENT;
			default: slot_of = `FHS_SLOT_NONE;
		endcase
	endfunction

	// default of each slot, shared by reset and programmed reset
	function automatic logic [7:0] rst_of(input int s);
		rst_of = (s == int'(`FHS_SLOT_MAIN)) ? `FHS_MAIN_RST : `FHS_CFG_RST;
	endfunction

	// address phase decode; only word transfers are expected
	// hsize is not decoded and upper address bits are ignored, so a
	// narrow or aliased access lands on the same eight-bit register
	assign aidx = haddr[9:2];
	assign atake = hsel & hready & htrans[`FHS_HTRANS_NONSEQ_BIT];
	assign dp_slot = slot_of(dp_idx_r);
	assign soft_rst = dp_wr_r && (dp_idx_r == `FHS_IDX_SOFT_RESET)
		&& hwdata[`FHS_SOFT_RESET_BIT];

	// remember a write until its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r <= 1'b0;
		end else begin
			dp_wr_r <= atake & hwrite; // hwdata arrives one cycle later
		end
	end

	// index of the last address phase; it is loaded on reads and idle
	// cycles too, which costs nothing because only dp_wr_r qualifies it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_idx_r <= `FHS_ZERO8;
		end else begin
			dp_idx_r <= aidx;
		end
	end

	// writable registers, eight bits each, upper data bits dropped
	// a programmed reset outranks a write landing in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int s = 0; s < `FHS_NUM_SLOTS; s++) begin
				cfg_r[s] <= rst_of(s);
			end
		end else if (soft_rst) begin
			for (int s = 0; s < `FHS_NUM_SLOTS; s++) begin
				cfg_r[s] <= rst_of(s);
			end
		end else if (dp_wr_r && dp_slot != `FHS_SLOT_NONE) begin
			cfg_r[dp_slot] <= hwdata[7:0];
		end
	end

	// own calibration results, read-only to software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_r <= '0;
		end else if (cal_done) begin
			res_r <= cal_result; // a fresh result wins over a programmed reset
		end else if (soft_rst) begin
			res_r <= '0;
		end
	end

	// read data for the coming data phase; a write still in its data
	// phase is forwarded so back-to-back write then read sees it
	always_comb begin
		logic [3:0] s;
		s = slot_of(aidx);
		rd_word = '0;
		if (s != `FHS_SLOT_NONE) begin
			if (soft_rst) begin
				rd_word[7:0] = rst_of(int'(s));
			end else if (dp_wr_r && dp_idx_r == aidx) begin
				rd_word[7:0] = hwdata[7:0];
			end else begin
				rd_word[7:0] = cfg_r[s];
			end
		end else begin
			case (aidx)
				`FHS_IDX_RES_PUMP: rd_word[3:0] = res_r.pump;
				`FHS_IDX_RES_OSC_ARRAY: rd_word[4:0] = res_r.osc_array;
				`FHS_IDX_RES_OSC_CURRENT: rd_word[5:0] = res_r.osc_current;
				default: rd_word = '0; // unmapped reads as zero
			endcase
		end
	end

	// bus answer: zero wait states, so the data phase is always the
	// cycle right after the address phase; read data stands for that
	// one cycle and is zero otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (atake && !hwrite) begin
			hrdata <= rd_word;
		end else begin
			hrdata <= '0; // idle bus reads as zero
		end
	end

	// ready stays high, also during reset, so the bus never stalls here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// every transfer, mapped or not, is answered okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= `FHS_HRESP_OKAY;
		end else begin
			hresp <= `FHS_HRESP_OKAY;
		end
	end

	// views of the register fields for the selector
	// both the pump and the array force enables live in the array
	// override register; the pump override register holds only a value
	assign fa = {cfg_r[`FHS_SLOT_FREQ2A], cfg_r[`FHS_SLOT_FREQ1A], cfg_r[`FHS_SLOT_FREQ0A]};
	assign fb = {cfg_r[`FHS_SLOT_FREQ2B], cfg_r[`FHS_SLOT_FREQ1B], cfg_r[`FHS_SLOT_FREQ0B]};
	assign fen.pump = cfg_r[`FHS_SLOT_OVR_OSC_ARRAY][`FHS_PUMP_FORCE_BIT];
	assign fen.osc_array = cfg_r[`FHS_SLOT_OVR_OSC_ARRAY][`FHS_OSC_ARRAY_FORCE_BIT];
	assign fen.osc_current = cfg_r[`FHS_SLOT_OVR_OSC_CURRENT][`FHS_OSC_CURRENT_FORCE_BIT];
	assign fval.pump = cfg_r[`FHS_SLOT_OVR_PUMP][3:0];
	assign fval.osc_array = cfg_r[`FHS_SLOT_OVR_OSC_ARRAY][4:0];
	assign fval.osc_current = cfg_r[`FHS_SLOT_OVR_OSC_CURRENT][5:0];

	fhs_cal_mux u_mux (
		.fsel(cfg_r[`FHS_SLOT_MAIN][`FHS_MAIN_FSEL_BIT]),
		.freq_set_a(fa),
		.freq_set_b(fb),
		.force_en(fen),
		.forced(fval),
		.own(res_r),
		.freq_sel(freq_nxt),
		.cal_sel(cal_nxt)
	);

	// outputs one cycle behind the registers; the host orders its writes
	// (select first, overrides next) so a hop settles within four writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			synth_freq <= '0;
		end else begin
			synth_freq <= freq_nxt;
		end
	end

	// calibration values in use, forced or own per field
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			synth_cal <= '0;
		end else begin
			synth_cal <= cal_nxt;
		end
	end

	// active set indication, registered like the frequency word so
	// both change at the same edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_set_sel <= 1'b0;
		end else begin
			freq_set_sel <= cfg_r[`FHS_SLOT_MAIN][`FHS_MAIN_FSEL_BIT];
		end
	end
endmodule
`default_nettype wire

// ---- fhs_hop_regs_props.sv ----
// assertions on the hop register bank ports
`timescale 1ns/10ps
`default_nettype none
`include "fhs_consts.svh"
module fhs_hop_regs_props
	import fhs_pkg::*;
(
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, low
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // type
	input wire logic hwrite, // direction
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // ready in
	input wire logic [31:0] hrdata, // read data
	input wire logic hreadyout, // ready out
	input wire logic hresp, // response
	input wire logic cal_done, // result strobe
	input var fhs_freq_t synth_freq, // active frequency
	input var fhs_cal_t synth_cal, // calibration in use
	input wire logic freq_set_sel // active set
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take; // transfer accepted
	logic wr_ph_r; // write data phase
	logic rd_ph_r; // read data phase
	assign take = hsel && hready && htrans[1];
	// data phase flags trail the address phase by one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_r <= 1'b0;
			rd_ph_r <= 1'b0;
		end else begin
			wr_ph_r <= take && hwrite;
			rd_ph_r <= take && !hwrite;
		end
	end
	sequence s_wr(idx); take && hwrite && haddr[9:2] == idx; endsequence
	// a result strobe in the same cycle refills the results, so it is excluded
	sequence s_soft;
		s_wr(`FHS_IDX_SOFT_RESET) ##1 hwdata[`FHS_SOFT_RESET_BIT] && !cal_done;
	endsequence
	// a write lands at the end of its data phase and the outputs follow one
	// edge later, so a change is sampled two edges after the data phase
	a_sel_follow: assert property (s_wr(`FHS_IDX_MAIN) |=> ##2
		freq_set_sel == $past(hwdata[`FHS_MAIN_FSEL_BIT], 2))
		else $error("set select not taken from main write");
	a_soft_clear: assert property (s_soft |=> ##1 !freq_set_sel && synth_freq == '0
		&& synth_cal == '0)
		else $error("programmed reset left state behind");
	a_rst_out: assert property ($rose(hresetn) |-> !freq_set_sel && synth_freq == '0
		&& hrdata == '0)
		else $error("outputs not at reset value");
	a_freq_hold: assert property (!$stable(synth_freq) |-> $past(wr_ph_r, 2))
		else $error("frequency moved without a write");
	a_cal_hold: assert property (!$stable(synth_cal) |-> $past(wr_ph_r, 2) || $past(cal_done, 2))
		else $error("calibration moved without cause");
	a_rd_idle: assert property (!rd_ph_r |-> hrdata == '0)
		else $error("read data outside data phase");
	a_rd_byte: assert property (rd_ph_r |-> hrdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
endmodule
bind fhs_hop_regs fhs_hop_regs_props fhs_hop_regs_props_i (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .cal_done, .synth_freq,
	.synth_cal, .freq_set_sel);
`default_nettype wire

// ---- fhs_pkg.sv ----
// types shared by the hop channel switch register bank
package fhs_pkg;
	// one set of synthesizer calibration values
	typedef struct packed {
		logic [3:0] pump;        // charge pump current
		logic [4:0] osc_array;   // oscillator array
		logic [5:0] osc_current; // oscillator calibration current
	} fhs_cal_t;

	// one frequency register set, most significant byte first
	typedef struct packed {
		logic [7:0] freq2;
		logic [7:0] freq1;
		logic [7:0] freq0;
	} fhs_freq_t;

	// force enables taken from the override registers
	typedef struct packed {
		logic pump;
		logic osc_array;
		logic osc_current;
	} fhs_force_t;
endpackage

// ---- tb_fhs_hop_regs.sv ----
// self-checking bench for the hop register bank
`timescale 1ns/10ps
`default_nettype none
`include "fhs_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_fhs_hop_regs;
	import fhs_pkg::*;
	logic hclk, hresetn, hsel, hwrite, go, cal_done, freq_set_sel, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] en;
	logic [3:0] dly;
	logic [31:0] haddr, hwdata, hrdata, q, d;
	fhs_cal_t val, cal_result, synth_cal, own, frc, prev;
	fhs_freq_t synth_freq, fa, fb;
	integer seed = 83798;
	int error_cnt = 0;
	int checked = 0;
	logic [7:0] idx_l [7] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h21};
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	fhs_hop_regs fhs_hop_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cal_done,
		.cal_result, .synth_freq, .synth_cal, .freq_set_sel);
	fhs_cal_engine_model fhs_cal_engine_model_i (.hclk, .go, .dly, .val, .cal_done, .cal_result);
	// one word transfer; each phase held until ready is seen
	task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] v);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		xfer(idx, 1'b0, 32'h0);
		`CHK(q, {24'h0, e})
	endtask
	// outputs follow register state one edge later
	task automatic settle;
		@(posedge hclk);
		#1;
	endtask
	// calibration in use: forced field where its enable is set
	function automatic fhs_cal_t pick(input logic [2:0] e, input fhs_cal_t f, input fhs_cal_t o);
		fhs_cal_t r;
		r.pump = e[2] ? f.pump : o.pump;
		r.osc_array = e[1] ? f.osc_array : o.osc_array;
		r.osc_current = e[0] ? f.osc_current : o.osc_current;
		return r;
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, go, dly, val} = '0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`FHS_IDX_MAIN, `FHS_MAIN_RST);
		for (int i = 0; i < 7; i++) rd(idx_l[i], `FHS_CFG_RST);
		// random bytes with junk in the upper lanes, plus an unmapped place
		for (int i = 0; i < 7; i++) begin
			d = $random(seed);
			xfer(idx_l[i], 1'b1, d);
			rd(idx_l[i], d[7:0]);
		end
		xfer(8'h30, 1'b1, 32'hFF);
		rd(8'h30, 8'h00);
		$display("test registers done");
		fa = 24'($random(seed));
		fb = 24'($random(seed));
		for (int i = 0; i < 3; i++) xfer(idx_l[i], 1'b1, {24'h0, fa[23-8*i -: 8]});
		xfer(`FHS_IDX_MAIN, 1'b1, 32'h0);
		settle();
		`CHK({freq_set_sel, synth_freq}, {1'b0, fa})
		// next channel goes into the idle set while set a stays live
		for (int i = 0; i < 3; i++) xfer(idx_l[3+i], 1'b1, {24'h0, fb[23-8*i -: 8]});
		settle();
		`CHK(synth_freq, fa)
		xfer(`FHS_IDX_MAIN, 1'b1, 32'h40);
		settle();
		`CHK({freq_set_sel, synth_freq}, {1'b1, fb})
		$display("test switch done");
		// one calibration per channel, the second hop replays stored results
		for (int k = 0; k < 2; k++) begin
			xfer(`FHS_IDX_OVR_OSC_ARRAY, 1'b1, 32'h0);
			xfer(`FHS_IDX_OVR_OSC_CURRENT, 1'b1, 32'h0);
			own = 15'($random(seed));
			@(posedge hclk);
			val <= own;
			dly <= k ? 4'h9 : 4'h0;
			go <= 1'b1;
			@(posedge hclk);
			go <= 1'b0;
			do @(posedge hclk); while (cal_done !== 1'b1);
			settle();
			`CHK(synth_cal, own)
			rd(`FHS_IDX_RES_PUMP, {4'h0, own.pump});
			rd(`FHS_IDX_RES_OSC_ARRAY, {3'h0, own.osc_array});
			rd(`FHS_IDX_RES_OSC_CURRENT, {2'h0, own.osc_current});
			// hop: select first, then the three override writes
			xfer(`FHS_IDX_MAIN, 1'b1, {25'h0, k[0], 6'h0});
			// first hop forces random values, the second the stored
			// results of the first channel, current value shared
			frc = k ? prev : 15'($random(seed));
			en = k ? 3'h7 : 3'($random(seed));
			xfer(`FHS_IDX_OVR_PUMP, 1'b1, {28'h0, frc.pump});
			xfer(`FHS_IDX_OVR_OSC_ARRAY, 1'b1, {25'h0, en[2:1], frc.osc_array});
			xfer(`FHS_IDX_OVR_OSC_CURRENT, 1'b1, {25'h0, en[0], frc.osc_current});
			settle();
			`CHK(synth_cal, pick(en, frc, own))
			prev = own;
		end
		$display("test override done");
		xfer(`FHS_IDX_SOFT_RESET, 1'b1, 32'h1);
		rd(`FHS_IDX_MAIN, `FHS_MAIN_RST);
		rd(`FHS_IDX_OVR_OSC_ARRAY, `FHS_CFG_RST);
		rd(`FHS_IDX_RES_PUMP, `FHS_ZERO8);
		`CHK({freq_set_sel, synth_cal}, 16'h0)
		$display("test soft reset done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
